// ===== pkg/pm_gpio_pkg.sv
// Summary of operation
// - Low ctrl bits 3,4: GPIO0/1 edge select
// - Low ctrl bit 5: GPIO2 edge, needs enable
// - GPIO0-2 interrupt only when enable bit set
// - GPIO0-2 events set top bit, status 5-7
// - Only GPIO0-2 wake from clock-stopped suspend
// - GPIO7 interrupt and timer reload independent
// - Misc bit 7: floppy primary or both
// - Misc bit 5: partial primary disk decode
// - Misc bit 4: partial secondary disk decode
// - Misc bit 1 mouse present, bit 0 port
// - Mouse port counts as keyboard, not serial
// - Off count times 32 us deasserted
// - On count times 32 us asserted
// - Speedup events restart both phase counters
// - Config bit 0 enables modulation
// - Interrupt pauses via timer or until read
// - Speedup config ignored when modulation off
// - Bit 4 disables power savings, bit 3 bus clock
// - Bit 2 enables low-voltage suspend mode
// - High ctrl: enables bits 3:0, edges 7:4
// - GPIO7,5,4,3 events set status 3..0
package pm_gpio_pkg;
  localparam logic [7:0] ADDR_MISC      = 8'h93;
  localparam logic [7:0] ADDR_OFF_CNT   = 8'h94;
  localparam logic [7:0] ADDR_ON_CNT    = 8'h95;
  localparam logic [7:0] ADDR_CPU_SUSPEND_REQUEST_N_CFG  = 8'h96;
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'h97;
  localparam logic [7:0] ADDR_CTRL_LOW  = 8'h92;
  localparam logic [7:0] ADDR_STAT_LOW  = 8'h87;
  localparam logic [7:0] ADDR_STAT_HIGH = 8'h84;
  localparam logic [7:0] ADDR_STAT_TOP  = 8'h80;
  localparam logic [7:0] ADDR_SPD_DIS   = 8'h08;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] MISC_RSVD_MASK = 8'h0c;
  localparam logic [7:0] CFG_RSVD_MASK  = 8'he0;
  localparam int MISC_FLOPPY_BOTH = 7;
  localparam int MISC_PART_PRI    = 5;
  localparam int MISC_PART_SEC    = 4;
  localparam int MISC_MOUSE_EN    = 1;
  localparam int MISC_MOUSE_PORT  = 0;
  localparam int CFG_PSAVE_DIS    = 4;
  localparam int CFG_BUSCLK       = 3;
  localparam int CFG_LOWV         = 2;
  localparam int CFG_SPD_READ     = 1;
  localparam int CFG_MOD_EN       = 0;
  localparam int  CLK_HZ       = 10_000_000;
  localparam int  TICK_US      = 32;
  localparam int  TICK_CYCLES  = TICK_US * (CLK_HZ / 1_000_000);
  localparam int  MS_CYCLES    = 1000 * (CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {
    MOD_IDLE = 3'b001,
    MOD_ON   = 3'b010,
    MOD_OFF  = 3'b100
  } mod_state_type;
endpackage

// ===== core/pm_gpio_smi_suspend_modulation.sv
`timescale 1ns/1ps
`default_nettype none
module pm_gpio_smi_suspend_modulation
  import pm_gpio_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES,
  parameter int MS_CNT   = MS_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Pins and observed I/O cycles
  input  wire logic [7:0] gpio_in,
  input  wire logic       clocks_stopped_in,
  input  wire logic       io_valid_in,
  input  wire logic       io_write_in,
  input  wire logic [9:0] io_addr_in,
  input  wire logic       irq_speedup_in,
  input  wire logic       video_speedup_in,
  input  wire logic [7:0] irq_speedup_count_in,
  input  wire logic [7:0] video_speedup_count_in,
  // Outputs, plus the timer 2 reload enable and edge inputs
  output logic            mgmt_interrupt_out,
  output logic            wake_out,
  output logic            gp_timer2_reload_out,
  input  wire logic       gp_timer2_reload_en_in,
  input  wire logic       gp_timer2_edge_in,
  output logic            cpu_suspend_request_n_out,
  output logic            power_save_en_out,
  output logic            bus_clock_save_out,
  output logic            low_volt_suspend_out,
  output logic            floppy_activity_out,
  output logic            hdd_pri_activity_out,
  output logic            hdd_sec_activity_out,
  output logic            serial_activity_out,
  output logic            kbd_mouse_activity_out
);

  logic [7:0] misc_q, off_cnt_q, on_cnt_q, cfg_q, ctrl_high_q, ctrl_low_q;
  logic [7:0] stat_low_q, stat_high_q;
  logic       stat_top_q;
  logic [7:0] gpio_prev_q;
  logic [7:0] rise, fall;
  logic [2:0] ev_low;
  logic [3:0] ev_high;
  logic [7:0] rd_d;

  // Returns the pin edge picked by the edge-select bit: 0 rising, 1 falling
  function automatic logic edge_sel(input logic r, input logic f, input logic sel);
    edge_sel = sel ? f : r;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      // Follow the pins in reset too, so a pin idling high gives no false edge after it
      gpio_prev_q <= gpio_in;
    end else begin
      gpio_prev_q <= gpio_in;
    end
  end

  assign rise = gpio_in & ~gpio_prev_q;
  assign fall = ~gpio_in & gpio_prev_q;

  // GPIO0..2 events: enable in low control 2:0, edge in 5:3
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ev_low[i] = ctrl_low_q[i] & edge_sel(rise[i], fall[i], ctrl_low_q[3+i]);
    end
  end

  // GPIO3,4,5,7 events: enable in high control 3:0, edge in 7:4
  assign ev_high[0] = ctrl_high_q[0] & edge_sel(rise[3], fall[3], ctrl_high_q[4]);
  assign ev_high[1] = ctrl_high_q[1] & edge_sel(rise[4], fall[4], ctrl_high_q[5]);
  assign ev_high[2] = ctrl_high_q[2] & edge_sel(rise[5], fall[5], ctrl_high_q[6]);
  assign ev_high[3] = ctrl_high_q[3] & edge_sel(rise[7], fall[7], ctrl_high_q[7]);

  // Timer reload on GPIO7 is separate from its interrupt enable
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      gp_timer2_reload_out <= 1'b0;
    end else begin
      gp_timer2_reload_out <= gp_timer2_reload_en_in &
                              edge_sel(rise[7], fall[7], gp_timer2_edge_in);
    end
  end

  // Only the GPIO0..2 sources may wake while clocks are stopped
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= clocks_stopped_in & (|ev_low);
    end
  end

  // Status: reading a status register clears it; a new event in that cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      stat_low_q  <= REG_RESET;
      stat_high_q <= REG_RESET;
      stat_top_q  <= 1'b0;
    end else begin
      stat_low_q  <= ((reg_rd_in && reg_addr_in == ADDR_STAT_LOW) ? 8'h00 : stat_low_q)
                     | {ev_low, 5'h00};
      stat_high_q <= ((reg_rd_in && reg_addr_in == ADDR_STAT_HIGH) ? 8'h00 : stat_high_q)
                     | {4'h0, ev_high};
      stat_top_q  <= ((reg_rd_in && reg_addr_in == ADDR_STAT_TOP) ? 1'b0 : stat_top_q)
                     | (|ev_low) | (|ev_high);
    end
  end

  assign mgmt_interrupt_out = stat_top_q;

  // Register writes; reserved bits are stored as written
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      misc_q      <= REG_RESET;
      off_cnt_q   <= REG_RESET;
      on_cnt_q    <= REG_RESET;
      cfg_q       <= REG_RESET;
      ctrl_high_q <= REG_RESET;
      ctrl_low_q  <= REG_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_MISC:      misc_q      <= reg_wdata_in;
        ADDR_OFF_CNT:   off_cnt_q   <= reg_wdata_in;
        ADDR_ON_CNT:    on_cnt_q    <= reg_wdata_in;
        ADDR_CPU_SUSPEND_REQUEST_N_CFG:  cfg_q       <= reg_wdata_in;
        ADDR_CTRL_HIGH: ctrl_high_q <= reg_wdata_in;
        ADDR_CTRL_LOW:  ctrl_low_q  <= reg_wdata_in;
        default:        ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr_in)
      ADDR_MISC:      rd_d = misc_q;
      ADDR_OFF_CNT:   rd_d = off_cnt_q;
      ADDR_ON_CNT:    rd_d = on_cnt_q;
      ADDR_CPU_SUSPEND_REQUEST_N_CFG:  rd_d = cfg_q;
      ADDR_CTRL_HIGH: rd_d = ctrl_high_q;
      ADDR_CTRL_LOW:  rd_d = ctrl_low_q;
      ADDR_STAT_LOW:  rd_d = stat_low_q;
      ADDR_STAT_HIGH: rd_d = stat_high_q;
      ADDR_STAT_TOP:  rd_d = {7'h00, stat_top_q};
      default:        rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= REG_RESET;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_d : 8'h00;
    end
  end

  // Configuration outputs
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      power_save_en_out    <= 1'b0;
      bus_clock_save_out   <= 1'b0;
      low_volt_suspend_out <= 1'b0;
    end else begin
      power_save_en_out    <= ~cfg_q[CFG_PSAVE_DIS];
      bus_clock_save_out   <= ~cfg_q[CFG_PSAVE_DIS] & cfg_q[CFG_BUSCLK];
      low_volt_suspend_out <= cfg_q[CFG_LOWV];
    end
  end

  // Activity decode of observed I/O cycles
  logic fdd_hit, pri_hit, sec_hit, com1_hit, com2_hit, lpt_hit, com34_hit, mouse_hit, kbd_hit;
  always_comb begin
    fdd_hit = io_addr_in == 10'h3f2 || io_addr_in == 10'h3f4 || io_addr_in == 10'h3f5 ||
              io_addr_in == 10'h3f7;
    if (misc_q[MISC_FLOPPY_BOTH]) begin
      fdd_hit = fdd_hit || io_addr_in == 10'h372 || io_addr_in == 10'h373 ||
                io_addr_in == 10'h375 || io_addr_in == 10'h377;
    end
    pri_hit = misc_q[MISC_PART_PRI] ?
              (io_write_in && (io_addr_in == 10'h1f6 || io_addr_in == 10'h1f7)) :
              (io_addr_in[9:3] == 7'h3e || io_addr_in == 10'h3f6);
    sec_hit = misc_q[MISC_PART_SEC] ?
              (io_write_in && (io_addr_in == 10'h176 || io_addr_in == 10'h177)) :
              (io_addr_in[9:3] == 7'h2e || io_addr_in == 10'h376);
    com1_hit  = io_addr_in[9:3] == 7'h7f;
    com2_hit  = io_addr_in[9:3] == 7'h5f;
    com34_hit = io_addr_in[9:3] == 7'h7d || io_addr_in[9:3] == 7'h5d;
    lpt_hit   = io_addr_in[9:3] == 7'h6f || io_addr_in[9:3] == 7'h4f;
    mouse_hit = misc_q[MISC_MOUSE_EN] &&
                (misc_q[MISC_MOUSE_PORT] ? com2_hit : com1_hit);
    kbd_hit   = io_addr_in == 10'h060 || io_addr_in == 10'h064;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      floppy_activity_out    <= 1'b0;
      hdd_pri_activity_out   <= 1'b0;
      hdd_sec_activity_out   <= 1'b0;
      serial_activity_out    <= 1'b0;
      kbd_mouse_activity_out <= 1'b0;
    end else begin
      floppy_activity_out    <= io_valid_in & fdd_hit;
      hdd_pri_activity_out   <= io_valid_in & pri_hit;
      hdd_sec_activity_out   <= io_valid_in & sec_hit;
      serial_activity_out    <= io_valid_in & ((lpt_hit | com34_hit | com1_hit | com2_hit)
                                & ~mouse_hit);
      kbd_mouse_activity_out <= io_valid_in & (kbd_hit | mouse_hit);
    end
  end

  // Speedup pause: timer in 1 ms units, or hold until the disable register is read
  logic        mod_en;
  logic        spd_hold_q;
  logic [7:0]  spd_ms_q;
  logic [15:0] ms_div_q;
  logic        smi_rise, speedup_ev, paused;
  logic        top_prev_q;

  assign mod_en     = cfg_q[CFG_MOD_EN];
  assign smi_rise   = stat_top_q & ~top_prev_q;
  assign speedup_ev = mod_en & (irq_speedup_in | video_speedup_in |
                      (smi_rise & ~cfg_q[CFG_SPD_READ]));
  assign paused     = spd_hold_q | (spd_ms_q != 8'h00);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      top_prev_q <= 1'b0;
      spd_hold_q <= 1'b0;
      spd_ms_q   <= 8'h00;
      ms_div_q   <= 16'h0000;
    end else begin
      top_prev_q <= stat_top_q;
      if (!mod_en) begin
        spd_hold_q <= 1'b0;
        spd_ms_q   <= 8'h00;
        ms_div_q   <= 16'h0000;
      end else begin
        if (smi_rise && cfg_q[CFG_SPD_READ]) begin
          spd_hold_q <= 1'b1;
        end else if (reg_rd_in && reg_addr_in == ADDR_SPD_DIS) begin
          spd_hold_q <= 1'b0;
        end
        if (speedup_ev) begin
          spd_ms_q <= video_speedup_in ? video_speedup_count_in : irq_speedup_count_in;
          ms_div_q <= 16'h0000;
        end else if (spd_ms_q != 8'h00) begin
          if (ms_div_q == 16'(MS_CNT - 1)) begin
            ms_div_q <= 16'h0000;
            spd_ms_q <= spd_ms_q - 8'h01;
          end else begin
            ms_div_q <= ms_div_q + 16'h0001;
          end
        end
      end
    end
  end

  // Modulation: 32 us tick and phase counter
  mod_state_type state_q;
  logic [9:0]    tick_q;
  logic [7:0]    phase_q;
  logic          tick;

  assign tick = tick_q == 10'(TICK_CNT - 1);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_q <= MOD_IDLE;
      tick_q  <= 10'h000;
      phase_q <= 8'h00;
    end else if (!mod_en || paused || speedup_ev) begin
      state_q <= MOD_IDLE;
      tick_q  <= 10'h000;
      phase_q <= 8'h00;
    end else begin
      tick_q <= tick ? 10'h000 : tick_q + 10'h001;
      case (state_q)
        MOD_IDLE: begin
          state_q <= MOD_ON;
          phase_q <= on_cnt_q;
          tick_q  <= 10'h000;
        end
        MOD_ON: begin
          if (tick && phase_q <= 8'h01) begin
            state_q <= MOD_OFF;
            phase_q <= off_cnt_q;
          end else if (tick) begin
            phase_q <= phase_q - 8'h01;
          end
        end
        MOD_OFF: begin
          if (tick && phase_q <= 8'h01) begin
            state_q <= MOD_ON;
            phase_q <= on_cnt_q;
          end else if (tick) begin
            phase_q <= phase_q - 8'h01;
          end
        end
        default: state_q <= MOD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cpu_suspend_request_n_out <= 1'b1;
    end else begin
      cpu_suspend_request_n_out <= !(state_q == MOD_ON && on_cnt_q != 8'h00);
    end
  end

endmodule
`default_nettype wire

// ===== testbench/pm_gpio_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pm_gpio_sva (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rstn_in,
  // Observed inputs
  input wire logic [7:0] gpio_in,
  input wire logic       clocks_stopped_in,
  input wire logic       io_valid_in,
  input wire logic       io_write_in,
  input wire logic [9:0] io_addr_in,
  input wire logic       video_speedup_in,
  input wire logic [7:0] video_speedup_count_in,
  input wire logic       gp_timer2_reload_en_in,
  // Observed outputs
  input wire logic       mgmt_interrupt_out,
  input wire logic       wake_out,
  input wire logic       gp_timer2_reload_out,
  input wire logic       cpu_suspend_request_n_out,
  input wire logic       floppy_activity_out,
  input wire logic       hdd_pri_activity_out,
  input wire logic       hdd_sec_activity_out,
  input wire logic       serial_activity_out,
  input wire logic       kbd_mouse_activity_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  property p_wake;
    wake_out |-> $past(clocks_stopped_in) && $past(gpio_in[2:0]) != $past(gpio_in[2:0], 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without low pin edge");
  property p_reload;
    gp_timer2_reload_out |-> $past(gp_timer2_reload_en_in) && $past(gpio_in[7]) != $past(gpio_in[7], 2);
  endproperty
  a_reload: assert property (p_reload) else $error("reload without pin 7 edge");
  property p_irq;
    $rose(mgmt_interrupt_out) |-> $past(gpio_in) != $past(gpio_in, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without pin edge");
  property p_flop;
    io_valid_in && io_addr_in == 10'h3f2 |=> floppy_activity_out;
  endproperty
  a_flop: assert property (p_flop) else $error("primary floppy access missed");
  property p_pri;
    io_valid_in && io_write_in && io_addr_in == 10'h1f6 |=> hdd_pri_activity_out;
  endproperty
  a_pri: assert property (p_pri) else $error("primary disk write missed");
  property p_sec;
    io_valid_in && io_write_in && io_addr_in == 10'h177 |=> hdd_sec_activity_out;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary disk write missed");
  property p_mouse;
    serial_activity_out || kbd_mouse_activity_out |-> $past(io_valid_in) &&
      !(serial_activity_out && kbd_mouse_activity_out);
  endproperty
  a_mouse: assert property (p_mouse) else $error("serial and mouse activity clash");
  property p_spd;
    video_speedup_in && video_speedup_count_in != 8'h00 |-> ##[1:3] cpu_suspend_request_n_out;
  endproperty
  a_spd: assert property (p_spd) else $error("speedup did not release suspend");
  c_wake: cover property (wake_out);
  c_reload: cover property (gp_timer2_reload_out);
  c_mod: cover property ($fell(cpu_suspend_request_n_out));
endmodule
bind pm_gpio_smi_suspend_modulation pm_gpio_sva sva (.*);
`default_nettype wire

// ===== testbench/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic clk_sys_in,
  input  wire logic cpu_suspend_request_n_in,
  output int        low_len_out,
  output int        high_len_out
);
  int   run_q = 0;
  logic last_q = 1'b1;
  // Only finished runs are reported, so a run in progress never reads short
  always @(posedge clk_sys_in) begin
    run_q <= (cpu_suspend_request_n_in === last_q) ? run_q + 1 : 1;
    last_q <= cpu_suspend_request_n_in;
    if (cpu_suspend_request_n_in !== last_q && last_q) high_len_out <= run_q;
    if (cpu_suspend_request_n_in !== last_q && !last_q) low_len_out <= run_q;
  end
endmodule
`default_nettype wire

// ===== testbench/pm_gpio_smi_suspend_modulation_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pm_gpio_smi_suspend_modulation_tb_top;
  logic       clk_sys_in = 1'b0, rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, v;
  logic       reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] gpio_in = 8'h00, irq_speedup_count_in = 8'h04, video_speedup_count_in = 8'h04;
  logic       clocks_stopped_in = 1'b1, io_valid_in = 1'b0, io_write_in = 1'b0;
  logic [9:0] io_addr_in = 10'h000;
  logic       irq_speedup_in = 1'b0, video_speedup_in = 1'b0;
  logic       gp_timer2_reload_en_in = 1'b1, gp_timer2_edge_in = 1'b0;
  logic       mgmt_interrupt_out, wake_out, gp_timer2_reload_out, cpu_suspend_request_n_out;
  logic       power_save_en_out, bus_clock_save_out, low_volt_suspend_out;
  logic       floppy_activity_out, hdd_pri_activity_out, hdd_sec_activity_out;
  logic       serial_activity_out, kbd_mouse_activity_out;
  wire logic [7:0] cfg_flags = {5'b00000, power_save_en_out, bus_clock_save_out,
                                low_volt_suspend_out};
  wire logic [7:0] pin_flags = {5'b00000, mgmt_interrupt_out, wake_out, gp_timer2_reload_out};
  int         low_len, high_len, err_count = 0, compares = 0, cyc = 0;
  pm_gpio_smi_suspend_modulation #(.TICK_CNT(4), .MS_CNT(8)) dut (.*);
  cpu_core_model core (.clk_sys_in, .cpu_suspend_request_n_in(cpu_suspend_request_n_out),
    .low_len_out(low_len), .high_len_out(high_len));
  always #50 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit c = 1);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
    if (c) chk(v, e);
  endtask
  task automatic pe(input int p, input logic l, input logic [7:0] a, input logic [7:0] e,
                    input logic [2:0] f);
    @(posedge clk_sys_in);
    gpio_in[p] <= l;
    tick(2);
    // Wake and reload are one-cycle pulses: look while they stand
    chk(pin_flags, {5'b00000, f});
    rd(a, e);
  endtask
  task automatic t_regs;
    logic [7:0] al[10] = '{8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h92, 8'h87, 8'h84, 8'h80, 8'h55};
    foreach (al[i]) rd(al[i], 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'h93, 8'h40);
    rd(8'h93, 8'h40);
    $display("register test done");
  endtask
  task automatic t_low;
    for (int i = 0; i < 3; i++) begin
      wr(8'h92, (8'h08 << i) | (8'h01 << i));
      clocks_stopped_in <= (i != 2);
      pe(i, 1'b1, 8'h87, 8'h00, 3'b000);
      pe(i, 1'b0, 8'h87, 8'h20 << i, {1'b1, i != 2, 1'b0});
      rd(8'h80, 8'h01);
    end
    wr(8'h92, 8'h00);
    clocks_stopped_in <= 1'b1;
    pe(0, 1'b1, 8'h87, 8'h00, 3'b000);
    pe(0, 1'b0, 8'h87, 8'h00, 3'b000);
    $display("low pin test done");
  endtask
  task automatic t_high;
    int p[4] = '{3, 4, 5, 7};
    for (int j = 0; j < 4; j++) begin
      wr(8'h97, 8'h01 << j);
      pe(p[j], 1'b1, 8'h84, 8'h01 << j, {2'b10, j == 3});
      pe(p[j], 1'b0, 8'h84, 8'h00, 3'b100);
    end
    rd(8'h80, 8'h01);
    rd(8'h80, 8'h00);
    // Reload alone, with the interrupt off, on either chosen edge
    wr(8'h97, 8'h00);
    pe(7, 1'b1, 8'h84, 8'h00, 3'b001);
    @(posedge clk_sys_in);
    gp_timer2_edge_in <= 1'b1;
    pe(7, 1'b0, 8'h84, 8'h00, 3'b001);
    $display("high pin test done");
  endtask
  task automatic t_dec;
    logic [31:0] t[14] = '{32'h40_0_3f2_10, 32'h40_0_372_00, 32'hc0_0_372_10, 32'h40_0_1f0_08,
      32'h40_0_3f6_08, 32'h60_0_1f0_00, 32'h60_1_1f6_08, 32'h40_0_376_04, 32'h50_0_170_00,
      32'h50_1_177_04, 32'h40_0_3f8_02, 32'h42_0_3f8_01, 32'h43_0_3f8_02, 32'h43_0_2f8_01};
    foreach (t[i]) begin
      wr(8'h93, t[i][31:24]);
      @(posedge clk_sys_in);
      io_valid_in <= 1'b1; io_write_in <= t[i][20]; io_addr_in <= t[i][17:8];
      @(posedge clk_sys_in);
      io_valid_in <= 1'b0;
      #1 chk({3'b000, floppy_activity_out, hdd_pri_activity_out, hdd_sec_activity_out,
        serial_activity_out, kbd_mouse_activity_out}, t[i][7:0]);
    end
    $display("decode test done");
  endtask
  task automatic t_mod;
    wr(8'h94, 8'h02);
    wr(8'h95, 8'h03);
    wr(8'h96, 8'h01);
    tick(4);
    chk(8'(cpu_suspend_request_n_out), 8'h00);
    tick(60);
    chk(8'(low_len), 8'd12);
    chk(8'(high_len), 8'd8);
    wr(8'h95, 8'h01);
    tick(40);
    chk(8'(low_len), 8'd4);
    wr(8'h96, 8'h0c);
    tick(3);
    chk(cfg_flags, 8'h07);
    chk(8'(cpu_suspend_request_n_out), 8'h01);
    wr(8'h96, 8'h10);
    // Outputs are registered one edge after the write lands
    tick(2);
    chk(cfg_flags, 8'h00);
    $display("modulation test done");
  endtask
  task automatic t_speed;
    wr(8'h96, 8'h01);
    tick(6);
    @(posedge clk_sys_in);
    video_speedup_in <= 1'b1;
    @(posedge clk_sys_in);
    video_speedup_in <= 1'b0;
    irq_speedup_in <= 1'b1;
    @(posedge clk_sys_in);
    irq_speedup_in <= 1'b0;
    repeat (20) begin
      tick(1);
      #1 chk(8'(cpu_suspend_request_n_out), 8'h01);
    end
    // The speedup timer runs out and modulation starts again
    for (int k = 0; k < 40 && cpu_suspend_request_n_out !== 1'b0; k++) tick(1);
    chk(8'(cpu_suspend_request_n_out), 8'h00);
    // Timer mode: an interrupt loads the interrupt speedup count
    wr(8'h92, 8'h01);
    pe(0, 1'b1, 8'h87, 8'h20, 3'b110);
    repeat (4) begin
      tick(4);
      #1 chk(8'(cpu_suspend_request_n_out), 8'h01);
    end
    rd(8'h80, 8'h01);
    wr(8'h96, 8'h03);
    wr(8'h92, 8'h09);
    pe(0, 1'b0, 8'h87, 8'h20, 3'b110);
    repeat (10) begin
      tick(10);
      #1 chk(8'(cpu_suspend_request_n_out), 8'h01);
    end
    rd(8'h08, 8'h00, 0);
    for (int k = 0; k < 40 && cpu_suspend_request_n_out !== 1'b0; k++) tick(1);
    chk(8'(cpu_suspend_request_n_out), 8'h00);
    // With modulation off the read-hold choice must not latch a pause
    rd(8'h80, 8'h01);
    wr(8'h96, 8'h02);
    wr(8'h92, 8'h01);
    pe(0, 1'b1, 8'h87, 8'h20, 3'b110);
    wr(8'h96, 8'h01);
    tick(4);
    chk(8'(cpu_suspend_request_n_out), 8'h00);
    $display("speedup test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    tick(6);
    rstn_in <= 1'b1;
    t_regs;
    t_low;
    t_high;
    t_dec;
    t_mod;
    t_speed;
    print_verdict;
  end
endmodule
`default_nettype wire
